// >>> hw/dac_rx_pkg.sv
// shared constants and types for the quad converter write receiver
package dac_rx_pkg;
  // target address byte layout
  localparam logic [4:0] ADDR_PREFIX  = 5'h13;
  localparam int         ADDR_PFX_MSB = 7;
  localparam int         ADDR_PFX_LSB = 3;
  localparam int         ADDR_PIN_HI  = 2;
  localparam int         ADDR_PIN_LO  = 1;
  localparam int         ADDR_RW_BIT  = 0;
  // high-speed master code 0000 1xxx
  localparam logic [4:0] MCODE_PREFIX = 5'h01;
  // control byte fields
  localparam int CTRL_LOAD_MSB = 5;
  localparam int CTRL_LOAD_LSB = 4;
  localparam int CTRL_SEL_MSB  = 2;
  localparam int CTRL_SEL_LSB  = 1;
  localparam int CTRL_PD_BIT   = 0;
  // power-down byte fields
  localparam int PD_MODE_MSB = 7;
  localparam int PD_MODE_LSB = 6;
  // load modes
  localparam logic [1:0] LOAD_STAGE = 2'h0;
  localparam logic [1:0] LOAD_ONE   = 2'h1;
  localparam logic [1:0] LOAD_ALL   = 2'h2;
  localparam logic [1:0] LOAD_BCAST = 2'h3;
  // channel register width and count
  localparam int CH_W = 10;
  localparam int N_CH = 4;
  // update command queue: load, select, pd flag, value
  localparam int FIFO_WIDTH = 15;
  localparam int FIFO_DEPTH = 16;
  // reset values; pin order is {scl, sda, addr_hi, addr_lo}
  localparam logic [3:0]      SYNC_RESET = 4'hc;
  localparam logic [CH_W-1:0] CH_RESET   = 10'h000;
  localparam logic [7:0]      BYTE_RESET = 8'h00;
  localparam logic [3:0]      BITS_BYTE  = 4'h8;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_RX     = 2'b01,
    ST_ACK    = 2'b10,
    ST_IGNORE = 2'b11
  } rx_state_t;

  typedef enum logic [2:0] {
    PH_ADDR = 3'b000,
    PH_CTRL = 3'b001,
    PH_HI   = 3'b010,
    PH_LO   = 3'b011,
    PH_DONE = 3'b100
  } phase_t;
endpackage

// >>> hw/pin_filter.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module pin_filter #(
  parameter int         WIDTH    = 4,
  parameter logic [3:0] RESET_VL = 4'h0
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // raw and filtered levels
  input  wire logic [WIDTH-1:0] raw,
  output logic      [WIDTH-1:0] filt
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] filt_reg;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // s1 feeds only s2; a change counts once s2 and s3 agree
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          s1_reg[i]   <= RESET_VL[i];
          s2_reg[i]   <= RESET_VL[i];
          s3_reg[i]   <= RESET_VL[i];
          filt_reg[i] <= RESET_VL[i];
        end else begin
          s1_reg[i] <= raw[i];
          s2_reg[i] <= s1_reg[i];
          s3_reg[i] <= s2_reg[i];
          if (s2_reg[i] == s3_reg[i]) begin
            filt_reg[i] <= s3_reg[i];
          end
        end
      end
    end
  endgenerate

  assign filt = filt_reg;
endmodule

// >>> hw/cmd_fifo.sv
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module cmd_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  wire              full  = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                            (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  wire              empty = (wr_ptr_reg == rd_ptr_reg);
  wire              push  = in_valid && !full;
  wire              pop   = out_ready && !empty;

  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule

// >>> hw/dac_write_rx.sv
// two-wire target write receiver with per-channel staging and output registers
`timescale 1ns/1ps
module dac_write_rx
  import dac_rx_pkg::*;
(
  // clock and reset
  input  wire logic            CLK_SYS,
  input  wire logic            RST_B,
  // two-wire bus pins
  input  wire logic            SCL_I,
  input  wire logic            SDA_I,
  output logic                 SDA_O,
  output logic                 SDA_OE,
  // address straps
  input  wire logic            PIN_ADDRESS_HI,
  input  wire logic            PIN_ADDRESS_LO,
  // converter core handshake
  input  wire logic            APPLY_READY,
  output logic                 HS_ACTIVE,
  // channel output registers
  output logic      [CH_W-1:0] CH_OUT_A,
  output logic      [CH_W-1:0] CH_OUT_B,
  output logic      [CH_W-1:0] CH_OUT_C,
  output logic      [CH_W-1:0] CH_OUT_D
);
  ////////////////////////////////////////////////////////////////////////////
  // pin sampling and bus conditions
  logic [3:0] pin_f;
  logic       scl_q_reg;
  logic       sda_q_reg;

  pin_filter #(.WIDTH(4), .RESET_VL(SYNC_RESET)) u_pins (
    .clk   (CLK_SYS),
    .rst_b (RST_B),
    .raw   ({SCL_I, SDA_I, PIN_ADDRESS_HI, PIN_ADDRESS_LO}),
    .filt  (pin_f)
  );

  wire scl_f     = pin_f[3];
  wire sda_f     = pin_f[2];
  wire scl_rise  = scl_f && !scl_q_reg;
  wire scl_fall  = !scl_f && scl_q_reg;
  wire start_det = scl_f && scl_q_reg && sda_q_reg && !sda_f;
  wire stop_det  = scl_f && scl_q_reg && !sda_q_reg && sda_f;

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      scl_q_reg <= SYNC_RESET[3];
      sda_q_reg <= SYNC_RESET[2];
    end else begin
      scl_q_reg <= scl_f;
      sda_q_reg <= sda_f;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte receiver
  rx_state_t  state_reg;
  rx_state_t  state_next;
  phase_t     phase_reg;
  phase_t     phase_next;
  logic [7:0] shift_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] hi_reg;
  logic       hs_reg;
  logic       fifo_in_ready;

  wire byte_full = (bit_cnt_reg == BITS_BYTE);
  wire byte_done = (state_reg == ST_RX) && byte_full && scl_fall;
  wire ack_end   = (state_reg == ST_ACK) && scl_fall;
  wire bit_take  = (state_reg == ST_RX) && !byte_full && scl_rise;

  wire addr_hit = (shift_reg[ADDR_PFX_MSB:ADDR_PFX_LSB] == ADDR_PREFIX) &&
                  (shift_reg[ADDR_PIN_HI] == pin_f[1]) &&
                  (shift_reg[ADDR_PIN_LO] == pin_f[0]) &&
                  !shift_reg[ADDR_RW_BIT];
  wire mcode_hit = (phase_reg == PH_ADDR) &&
                   (shift_reg[ADDR_PFX_MSB:ADDR_PFX_LSB] == MCODE_PREFIX);
  wire pd_flag   = ctrl_reg[CTRL_PD_BIT];

  // the last byte of a pair is refused only while the queue is full
  wire ack_ok = ((phase_reg == PH_ADDR) && addr_hit) ||
                (phase_reg == PH_CTRL) ||
                (phase_reg == PH_HI) ||
                ((phase_reg == PH_LO) && fifo_in_ready);

  wire phase_adv_hi = (phase_reg == PH_LO) && !pd_flag;
  wire phase_adv_dn = (phase_reg == PH_LO) && pd_flag;

  always_comb begin
    state_next = state_reg;
    phase_next = phase_reg;
    if (stop_det) begin
      state_next = ST_IDLE;
    end else if (start_det) begin
      state_next = ST_RX;
      phase_next = PH_ADDR;
    end else if (byte_done) begin
      state_next = ack_ok ? ST_ACK : ST_IGNORE;
    end else if (ack_end) begin
      state_next = ST_RX;
      if (phase_adv_hi) begin
        phase_next = PH_HI;
      end else if (phase_adv_dn) begin
        phase_next = PH_DONE;
      end else if (phase_reg == PH_ADDR) begin
        phase_next = PH_CTRL;
      end else if (phase_reg == PH_CTRL) begin
        phase_next = PH_HI;
      end else begin
        phase_next = PH_LO;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      state_reg <= ST_IDLE;
      phase_reg <= PH_ADDR;
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_next;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      shift_reg   <= BYTE_RESET;
      bit_cnt_reg <= 4'h0;
    end else if (start_det || ack_end) begin
      bit_cnt_reg <= 4'h0;
    end else if (bit_take) begin
      shift_reg   <= {shift_reg[6:0], sda_f};
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_reg <= BYTE_RESET;
      hi_reg   <= BYTE_RESET;
    end else if (byte_done && ack_ok) begin
      if (phase_reg == PH_CTRL) begin
        ctrl_reg <= shift_reg;
      end
      if (phase_reg == PH_HI) begin
        hi_reg <= shift_reg;
      end
    end
  end

  // master code is never acknowledged; it only marks the fast phase
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      hs_reg <= 1'b0;
    end else if (stop_det) begin
      hs_reg <= 1'b0;
    end else if (byte_done && mcode_hit) begin
      hs_reg <= 1'b1;
    end
  end

  // open drain: the line is only ever pulled low during an ack clock
  assign SDA_O     = 1'b0;
  assign SDA_OE    = (state_reg == ST_ACK);
  assign HS_ACTIVE = hs_reg;

  ////////////////////////////////////////////////////////////////////////////
  // update queue
  logic [FIFO_WIDTH-1:0] push_data;
  logic [FIFO_WIDTH-1:0] pop_data;
  logic                  pop_valid;

  wire push = ack_end && (phase_reg == PH_LO);
  wire [CH_W-1:0] push_val = pd_flag ?
       {hi_reg[PD_MODE_MSB:PD_MODE_LSB], BYTE_RESET} :
       {2'b00, hi_reg};
  assign push_data = {ctrl_reg[CTRL_LOAD_MSB:CTRL_LOAD_LSB],
                      ctrl_reg[CTRL_SEL_MSB:CTRL_SEL_LSB],
                      pd_flag, push_val};

  cmd_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (CLK_SYS),
    .rst_b     (RST_B),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (push_data),
    .out_valid (pop_valid),
    .out_ready (APPLY_READY),
    .out_data  (pop_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // channel registers
  wire            pop     = pop_valid && APPLY_READY;
  wire [1:0]      q_load  = pop_data[14:13];
  wire [1:0]      q_sel   = pop_data[12:11];
  wire            q_pd    = pop_data[10];
  wire [CH_W-1:0] q_val   = pop_data[9:0];
  wire            q_bcast = (q_load == LOAD_BCAST);
  wire            q_one   = (q_load == LOAD_ONE) || (q_load == LOAD_ALL);

  logic [CH_W-1:0] stage_reg [N_CH];
  logic [CH_W-1:0] out_reg   [N_CH];

  genvar c;
  generate
    for (c = 0; c < N_CH; c++) begin : g_ch
      wire hit = (q_sel == 2'(c));
      // power-down keeps the stored data bits, only the mode changes
      wire [CH_W-1:0] new_val = q_pd ? {q_val[9:8], stage_reg[c][7:0]} : q_val;
      wire wr_stage = pop && ((hit && !q_bcast) || (q_bcast && q_sel[1]));
      wire ld_new   = pop && ((hit && q_one) || (q_bcast && q_sel[1]));
      wire ld_old   = pop && ((!hit && (q_load == LOAD_ALL)) ||
                              (q_bcast && !q_sel[1]));
      always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
          stage_reg[c] <= CH_RESET;
          out_reg[c]   <= CH_RESET;
        end else begin
          if (wr_stage) begin
            stage_reg[c] <= new_val;
          end
          if (ld_new) begin
            out_reg[c] <= new_val;
          end else if (ld_old) begin
            out_reg[c] <= stage_reg[c];
          end
        end
      end
    end
  endgenerate

  assign CH_OUT_A = out_reg[0];
  assign CH_OUT_B = out_reg[1];
  assign CH_OUT_C = out_reg[2];
  assign CH_OUT_D = out_reg[3];

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);

  sequence seq_byte_end;
    byte_done && !start_det && !stop_det;
  endsequence

  sequence seq_ack_hold;
    SDA_OE [*2];
  endsequence

  chk_mcode_nack: assert property (seq_byte_end ##0 mcode_hit |=> !SDA_OE [*3])
    else $error("master code was acknowledged");
  chk_addr_ack: assert property (
    seq_byte_end ##0 (phase_reg == PH_ADDR) && addr_hit |=> seq_ack_hold)
    else $error("matching address not acknowledged");
  chk_miss_quiet: assert property (
    seq_byte_end ##0 (phase_reg == PH_ADDR) && !addr_hit |=>
    !SDA_OE throughout (state_reg == ST_IGNORE) [*2])
    else $error("address miss drove the data line");
  chk_push_timing: assert property (
    push |-> $fell(scl_f) && SDA_OE && (phase_reg == PH_LO))
    else $error("update not at end of second ack");
  chk_pd_value: assert property (
    push && pd_flag |-> push_data[9:0] == {hi_reg[7:6], 8'h00})
    else $error("power-down value wrong");
  chk_data_value: assert property (
    push && !pd_flag |-> push_data[9:0] == {2'b00, hi_reg})
    else $error("data value wrong");
  chk_pd_two_bytes: assert property (
    seq_byte_end ##0 (phase_reg == PH_DONE) |=> (state_reg == ST_IGNORE))
    else $error("third power-down byte accepted");
  chk_pair_repeat: assert property (
    ack_end && !start_det && !stop_det && (phase_reg == PH_LO) && !pd_flag
    |=> (phase_reg == PH_HI) && (bit_cnt_reg == 4'h0))
    else $error("data pair did not repeat");
  chk_reload_all: assert property (
    pop && q_bcast && !q_sel[1] |=> out_reg[0] == $past(stage_reg[0]) &&
    out_reg[3] == $past(stage_reg[3]))
    else $error("reload from staging failed");
  chk_ctrl_pd: assert property (
    seq_byte_end ##0 (phase_reg == PH_CTRL) ##1 (state_reg == ST_ACK)
    |-> pd_flag == $past(shift_reg[0], 1))
    else $error("power-down flag not taken from control lsb");
endmodule

// >>> verif/bus_master_model.sv
// two-wire bus master model that writes to the receiver
`timescale 1ns/1ps
module bus_master_model (
  // clock
  input  wire logic clk,
  // link
  input  wire logic sda_in,
  output logic      scl,
  output logic      sda_low
);
  // bit period is HALF+1 clocks low and HALF-1 high, 160 ns in all; the long
  // low phase lets the receiver's filtered release of the line land before scl rises
  localparam int HALF = 4;

  // scl rests high between frames and only toggles inside them
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  // from idle or from inside a frame; inside a frame this is a repeated start
  task automatic start();
    if (!scl) begin
      sda_low = 1'b0;
      tick(HALF);
      scl = 1'b1;
      tick(HALF);
    end
    sda_low = 1'b1;
    tick(HALF);
    scl = 1'b0;
    tick(1);
  endtask

  task automatic stop();
    sda_low = 1'b1;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    sda_low = 1'b0;
    tick(HALF);
  endtask

  // msb first, then one acknowledge clock with the line released
  task automatic byte_out(input logic [7:0] v, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low = ~v[i];
      tick(HALF);
      scl = 1'b1;
      tick(HALF - 1);
      scl = 1'b0;
      tick(1);
    end
    sda_low = 1'b0;
    tick(HALF);
    scl = 1'b1;
    tick(HALF - 2);
    ack = ~sda_in;
    tick(1);
    scl = 1'b0;
    tick(1);
  endtask
endmodule

// >>> verif/dac_write_rx_tb.sv
// self-checking bench for the two-wire write receiver
`timescale 1ns/1ps
module dac_write_rx_tb;
  import dac_rx_pkg::*;

  typedef struct packed {
    logic [7:0]      ctrl;
    logic [7:0]      hi;
    logic [CH_W-1:0] a;
    logic [CH_W-1:0] b;
    logic [CH_W-1:0] c;
    logic [CH_W-1:0] d;
  } row_t;

  logic            clk         = 1'b0;
  logic            rst_b       = 1'b0;
  logic            pin_hi      = 1'b0;
  logic            pin_lo      = 1'b0;
  logic            apply_ready = 1'b1;
  logic [7:0]      addr_w      = 8'h98;
  logic            scl;
  logic            sda_low;
  wire logic       sda;
  logic            sda_o;
  logic            sda_oe;
  logic            hs_active;
  logic [CH_W-1:0] ch_a;
  logic [CH_W-1:0] ch_b;
  logic [CH_W-1:0] ch_c;
  logic [CH_W-1:0] ch_d;
  logic            ack;
  int              fails       = 0;
  int              checks      = 0;

  row_t rows [12] = '{
    '{8'h10, 8'h5a, 10'h05a, 10'h000, 10'h000, 10'h000},
    '{8'h12, 8'hab, 10'h05a, 10'h0ab, 10'h000, 10'h000},
    '{8'h06, 8'h33, 10'h05a, 10'h0ab, 10'h000, 10'h000},
    '{8'h24, 8'h44, 10'h05a, 10'h0ab, 10'h044, 10'h033},
    '{8'h13, 8'h80, 10'h05a, 10'h2ab, 10'h044, 10'h033},
    '{8'h36, 8'h77, 10'h077, 10'h077, 10'h077, 10'h077},
    '{8'h02, 8'h11, 10'h077, 10'h077, 10'h077, 10'h077},
    '{8'h30, 8'h00, 10'h077, 10'h011, 10'h077, 10'h077},
    '{8'h11, 8'h40, 10'h177, 10'h011, 10'h077, 10'h077},
    '{8'h11, 8'hc0, 10'h377, 10'h011, 10'h077, 10'h077},
    '{8'h11, 8'h00, 10'h077, 10'h011, 10'h077, 10'h077},
    '{8'h11, 8'h80, 10'h277, 10'h011, 10'h077, 10'h077}
  };

  always #10 clk = ~clk;

  // open-drain line with pull-up: low while either side pulls
  assign sda = (sda_oe ? sda_o : 1'b1) & ~sda_low;

  dac_write_rx dut (
    .CLK_SYS(clk), .RST_B(rst_b), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe),
    .PIN_ADDRESS_HI(pin_hi), .PIN_ADDRESS_LO(pin_lo), .APPLY_READY(apply_ready),
    .HS_ACTIVE(hs_active), .CH_OUT_A(ch_a), .CH_OUT_B(ch_b), .CH_OUT_C(ch_c), .CH_OUT_D(ch_d));

  bus_master_model m (.clk(clk), .sda_in(sda), .scl(scl), .sda_low(sda_low));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic cmp_bit(input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask

  task automatic cmp_ch(input logic [CH_W-1:0] a, b, c, d);
    checks++;
    if ({ch_a, ch_b, ch_c, ch_d} !== {a, b, c, d}) begin
      fails++;
      $display("Error at %0t: channels %h %h %h %h expected %h %h %h %h", $time,
               ch_a, ch_b, ch_c, ch_d, a, b, c, d);
    end
  endtask

  task automatic send(input logic [7:0] v, input logic exp_ack);
    m.byte_out(v, ack);
    cmp_bit(exp_ack, ack);
  endtask

  task automatic frame(input logic [7:0] ctrl, input logic [7:0] hi);
    m.start();
    send(addr_w, 1'b1);
    send(ctrl, 1'b1);
    send(hi, 1'b1);
    send(~hi, 1'b1);
    m.stop();
    wait_clk(20);
  endtask

  task automatic close_out();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    wait_clk(3);
    cmp_ch(CH_RESET, CH_RESET, CH_RESET, CH_RESET);
    cmp_bit(1'b0, hs_active);
    rst_b = 1'b1;
    wait_clk(6);
    foreach (rows[i]) begin
      frame(rows[i].ctrl, rows[i].hi);
      cmp_ch(rows[i].a, rows[i].b, rows[i].c, rows[i].d);
    end
    // foreign strap address, then a read request
    m.start();
    send(8'h9a, 1'b0);
    send(8'h12, 1'b0);
    m.start();
    send(8'h99, 1'b0);
    m.stop();
    pin_hi = 1'b1;
    pin_lo = 1'b1;
    addr_w = 8'h9e;
    m.start();
    send(8'h9a, 1'b0);
    frame(8'h16, 8'h21);
    cmp_ch(10'h277, 10'h011, 10'h077, 10'h021);
    pin_hi = 1'b0;
    pin_lo = 1'b0;
    addr_w = 8'h98;
    // high-speed entry, two pairs, restart into a power-down write
    m.start();
    send(8'h0d, 1'b0);
    cmp_bit(1'b1, hs_active);
    m.start();
    send(addr_w, 1'b1);
    send(8'h14, 1'b1);
    send(8'h12, 1'b1);
    wait_clk(10);
    cmp_ch(10'h277, 10'h011, 10'h077, 10'h021);
    send(8'hed, 1'b1);
    wait_clk(10);
    cmp_ch(10'h277, 10'h011, 10'h012, 10'h021);
    send(8'h34, 1'b1);
    send(8'hcb, 1'b1);
    m.start();
    send(addr_w, 1'b1);
    send(8'h17, 1'b1);
    send(8'h40, 1'b1);
    send(8'h00, 1'b1);
    send(8'h55, 1'b0);
    m.stop();
    wait_clk(20);
    cmp_ch(10'h277, 10'h011, 10'h034, 10'h121);
    cmp_bit(1'b0, hs_active);
    // core stalled: the queue fills and the overflowing pair is refused
    apply_ready = 1'b0;
    m.start();
    send(addr_w, 1'b1);
    send(8'h10, 1'b1);
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      send(8'(i + 1), 1'b1);
      send(8'h00, 1'b1);
    end
    send(8'hf0, 1'b1);
    send(8'h00, 1'b0);
    m.stop();
    cmp_ch(10'h277, 10'h011, 10'h034, 10'h121);
    apply_ready = 1'b1;
    wait_clk(40);
    cmp_ch(10'h010, 10'h011, 10'h034, 10'h121);
    // second reset in mid-run
    rst_b = 1'b0;
    wait_clk(1);
    cmp_ch(CH_RESET, CH_RESET, CH_RESET, CH_RESET);
    cmp_bit(1'b0, sda_oe);
    // release again: broadcast power-down, then load-all from staging
    rst_b = 1'b1;
    wait_clk(6);
    frame(8'h37, 8'hc0);
    cmp_ch(10'h300, 10'h300, 10'h300, 10'h300);
    frame(8'h26, 8'h3c);
    cmp_ch(10'h300, 10'h300, 10'h300, 10'h03c);
    close_out();
  end

  // the whole sequence needs about 9000 clocks, a little under half of this span
  initial begin
    #400000;
    fails++;
    close_out();
  end
endmodule
